// ---- hdl/gpc_pin_control.sv ----
// General-purpose pin control: control, input, output and output-enable
// registers on the paged management register port, plus pin drivers.
// Assumes one global copy serves all PHY ports and that the management
// controller presents one-cycle read and write strobes on sys_clk.
// Pad cells, LED drivers and the page-wide register port live outside;
// this block only decides values, enables and what a read returns.
`timescale 1ns/1ns
`default_nettype none

module gpc_pin_control #(
  parameter int LED_COUNT = 4
) (
  input wire logic sys_clk, // 125 MHz system clock
  input wire logic reset, // Hard device reset, active high
  input wire logic [4:0] reg_addr, // Management register index
  input wire logic reg_wr_en, // One-cycle write strobe
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_rd_en, // One-cycle read strobe
  output logic [15:0] reg_rdata, // Read data, valid the cycle after rd
  input wire logic [7:0] low_pins_reg_ctrl, // Pins 0-7 under register ctrl
  input wire logic [14:0] gp_pin_in, // Pin levels from pads
  output logic [14:0] gp_pin_out, // Pin drive values
  output logic [14:0] gp_pin_oe, // Pin output enables, high drives
  input wire logic low_power_hold_pin_in, // Hold pin level from pad
  output logic low_power_hold_pin_out, // Hold pin drive value
  output logic low_power_hold_pin_oe, // Hold pin output enable
  input wire logic [LED_COUNT-1:0] led_value, // LED levels wanted
  output logic [LED_COUNT-1:0] led_out, // LED pad drive values
  output logic [LED_COUNT-1:0] led_oe // LED pad output enables
);

  // Register state; all of it is hard-reset only and shared by every port
  logic [15:0] page_ff;
  logic [15:0] ctrl_two_ff;
  logic [14:0] out_values_ff;
  logic [14:0] out_enable_ff;
  logic [15:0] rdata_ff;
  logic [15:0] levels_sync;
  logic [15:0] nxt_rdata;

  // Decodes and views, kept as named wires so a probe can find them
  wire gp_page;
  wire wr_ctrl;
  wire wr_out;
  wire wr_oe;
  wire wr_page;
  wire [14:0] reg_owned;
  wire [15:0] ctrl_two_view;
  wire [15:0] in_levels_view;
  wire led_tristate;

  // Decode a two-bit pin selection field
  // Shared by the upper field and the four single-pin fields
  function automatic logic sel_is_regs(input logic [1:0] code);
    sel_is_regs = (code == gpc_pkg::SEL_REGS);
  endfunction : sel_is_regs

  // Refuse a build with no LED pads at elaboration;
  // the enable mux needs at least one bit.
  if (LED_COUNT < 1) begin : g_bad_led_count
    $error("gpc_pin_control: LED_COUNT must be at least 1");
  end

  // Hold pin rides as the top bit so bit 11 and the input register share
  // one synchroniser; a level shows about four cycles after it settles.
  // synchronise pin levels
  gpc_in_sync #(
    .WIDTH(16)
  ) u_in_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({low_power_hold_pin_in, gp_pin_in}),
    .level_ff(levels_sync)
  );

  // The page register is decoded whatever page is active, so the host
  // can always find its way back to the main page.
  // page gating of the pin registers
  assign gp_page = (page_ff == gpc_pkg::PAGE_GP);
  assign wr_page = reg_wr_en && (reg_addr == gpc_pkg::ADDR_PAGE);
  assign wr_ctrl = reg_wr_en && gp_page &&
                   (reg_addr == gpc_pkg::ADDR_CTRL_TWO);
  assign wr_out = reg_wr_en && gp_page &&
                  (reg_addr == gpc_pkg::ADDR_OUT_VALUES);
  assign wr_oe = reg_wr_en && gp_page &&
                 (reg_addr == gpc_pkg::ADDR_OUT_ENABLE);

  // Any 16-bit value is stored; only 0x0010 opens the pin registers.
  // hard reset only, single shared copy
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      page_ff <= gpc_pkg::PAGE_MAIN;
    end else if (wr_page) begin
      page_ff <= reg_wdata;
    end
  end

  // Bits 11 and 8 are masked to zero here; 11 is rebuilt from the pin on
  // read, so a write can never fake a pin level.
  // reserved bit 8 kept zero by write mask
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_two_ff <= gpc_pkg::CTRL_TWO_RST;
    end else if (wr_ctrl) begin
      ctrl_two_ff <= reg_wdata & gpc_pkg::CTRL_TWO_WR_MASK;
    end
  end

  // Only pins handed to the data registers ever show this value on a pad.
  // output values, bit 15 not stored
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_values_ff <= gpc_pkg::OUT_VALUES_RST;
    end else if (wr_out) begin
      out_values_ff <= reg_wdata[14:0];
    end
  end

  // The enable register sits beside the output register at 0x11.
  // per-pin direction, all inputs after reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_enable_ff <= gpc_pkg::OUT_ENABLE_RST;
    end else if (wr_oe) begin
      out_enable_ff <= reg_wdata[14:0];
    end
  end

  // A reserved code leaves the pin unclaimed here; it simply floats,
  // which is the safe state for a pin nobody owns.
  // one field owns pins twelve to fourteen together
  assign reg_owned[14:12] = {3{sel_is_regs(
    ctrl_two_ff[gpc_pkg::UPPER_SEL_LSB +: 2])}};
  // one field per pin for eight to eleven
  assign reg_owned[11] = sel_is_regs(
    ctrl_two_ff[gpc_pkg::PIN11_SEL_LSB +: 2]);
  assign reg_owned[10] = sel_is_regs(
    ctrl_two_ff[gpc_pkg::PIN10_SEL_LSB +: 2]);
  assign reg_owned[9] = sel_is_regs(
    ctrl_two_ff[gpc_pkg::PIN9_SEL_LSB +: 2]);
  assign reg_owned[8] = sel_is_regs(
    ctrl_two_ff[gpc_pkg::PIN8_SEL_LSB +: 2]);
  // Pins 0 to 7 take their ownership from the neighbouring control block.
  assign reg_owned[7:0] = low_pins_reg_ctrl;

  // pins drive only when owned and enabled; reserved codes float
  assign gp_pin_oe = reg_owned & out_enable_ff;
  // drive values straight from the output register
  assign gp_pin_out = out_values_ff;

  // Reset leaves the hold pin an input, so the board level wins until
  // software asks to drive it.
  // active-low enable for the hold pin
  assign low_power_hold_pin_oe = ~ctrl_two_ff[gpc_pkg::HOLD_OE_N_BIT];
  // hold pin value from bit 12
  assign low_power_hold_pin_out = ctrl_two_ff[gpc_pkg::HOLD_OUT_BIT];

  // Trade-off: in tri-state mode a high LED level depends on the board
  // pull-up, so its rise time is the pull-up's, not the pad's.
  // tri-state mode releases high levels for external pull-ups
  assign led_tristate = ctrl_two_ff[gpc_pkg::LED_TRI_BIT];
  // The value always mirrors the request; only the enable changes
  assign led_out = led_value;
  assign led_oe = led_tristate ? ~led_value : {LED_COUNT{1'b1}};

  // bit 11 always reflects the synchronised hold pin level
  assign ctrl_two_view = {ctrl_two_ff[15:12],
                          levels_sync[15],
                          ctrl_two_ff[10:9],
                          1'b0,
                          ctrl_two_ff[7:0]};

  // input levels, reserved bit reads zero
  assign in_levels_view = {1'b0, levels_sync[14:0]};

  // A read and a write in one cycle return the old value, as the view is
  // taken before the edge that stores the write.
  // Read mux; off-page or unmapped indices read as zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_addr == gpc_pkg::ADDR_PAGE) begin
      nxt_rdata = page_ff;
    end else if (gp_page) begin
      case (reg_addr)
        gpc_pkg::ADDR_CTRL_TWO: nxt_rdata = ctrl_two_view;
        gpc_pkg::ADDR_IN_LEVELS: nxt_rdata = in_levels_view;
        gpc_pkg::ADDR_OUT_VALUES: nxt_rdata = {1'b0, out_values_ff};
        gpc_pkg::ADDR_OUT_ENABLE: nxt_rdata = {1'b0, out_enable_ff};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  // Holding the data lets a slow host look late without a second strobe.
  // Registered read data; holds until the next read strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Read data straight from the register, no gate on the path
  assign reg_rdata = rdata_ff;

endmodule : gpc_pin_control

`default_nettype wire

// ---- hdl/gpc_pkg.sv ----
// Package for the general-purpose pin control block.
// Holds register indices, field positions, reset values and masks shared
// by the register file and the pin drivers.
package gpc_pkg;

  // Register indices on the paged management interface
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h0e;
  localparam logic [4:0] ADDR_IN_LEVELS = 5'h0f;
  localparam logic [4:0] ADDR_OUT_VALUES = 5'h10;
  localparam logic [4:0] ADDR_OUT_ENABLE = 5'h11;
  localparam logic [4:0] ADDR_PAGE = 5'h1f;

  // Page select values
  localparam logic [15:0] PAGE_GP = 16'h0010;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;

  // Control register field positions
  localparam int UPPER_SEL_LSB = 14;
  localparam int HOLD_OE_N_BIT = 13;
  localparam int HOLD_OUT_BIT = 12;
  localparam int HOLD_IN_BIT = 11;
  localparam int RSVD_RW_BIT = 10;
  localparam int LED_TRI_BIT = 9;
  localparam int RSVD_RO_BIT = 8;
  localparam int PIN11_SEL_LSB = 6;
  localparam int PIN10_SEL_LSB = 4;
  localparam int PIN9_SEL_LSB = 2;
  localparam int PIN8_SEL_LSB = 0;

  // Selection code that hands a pin to the data registers
  localparam logic [1:0] SEL_REGS = 2'h3;

  // Reset values
  localparam logic [15:0] CTRL_TWO_RST = 16'h2400;
  localparam logic [14:0] OUT_VALUES_RST = 15'h0000;
  localparam logic [14:0] OUT_ENABLE_RST = 15'h0000;

  // Writable bits of the control register (bits 11 and 8 are read-only)
  localparam logic [15:0] CTRL_TWO_WR_MASK = 16'hf6ff;

  // Number of general-purpose pins
  localparam int GP_PINS = 15;

endpackage : gpc_pkg

// ---- hdl/gpc_in_sync.sv ----
// Input synchroniser for pin levels arriving from outside the clock domain.
// Assumes sys_clk is free-running; level_ff follows a pin once the second
// and third stages agree.
`timescale 1ns/1ns
`default_nettype none

module gpc_in_sync #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // Raw pin levels
  output logic [WIDTH-1:0] level_ff // Filtered, synchronised levels
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  wire [WIDTH-1:0] agree;
  wire [WIDTH-1:0] nxt_level;

  // Refuse an empty bus at elaboration rather than build nothing
  if (WIDTH < 1) begin : g_bad_width
    $error("gpc_in_sync: WIDTH must be at least 1");
  end

  // Only bits where stages two and three agree may move the output
  assign agree = ~(stage2_ff ^ stage3_ff);
  assign nxt_level = (agree & stage3_ff) | (~agree & level_ff);

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
      level_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff <= nxt_level;
    end
  end

endmodule : gpc_in_sync

`default_nettype wire

// ---- verif/gpc_board_model.sv ----
// Board-side model of the general-purpose and low-power hold pins.
// Assumes the bench sets the levels that outside parts try to drive.
`timescale 1ns/1ns
`default_nettype none
module gpc_board_model (
  input wire logic [14:0] ext_lvl, // Board levels
  input wire logic ext_hold, // Board hold level
  input wire logic [14:0] pin_out, // Device values
  input wire logic [14:0] pin_oe, // Device enables
  input wire logic hold_out, // Device hold value
  input wire logic hold_oe, // Device hold enable
  output logic [14:0] pin_lvl, // Resolved pin wires
  output logic hold_lvl // Resolved hold wire
);
  // Board parts are weak, so a driving device always wins the wire
  assign pin_lvl = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
  assign hold_lvl = hold_oe ? hold_out : ext_hold;
endmodule : gpc_board_model
`default_nettype wire

// ---- verif/gpc_pin_control_asserts.sv ----
// Checker for the pin control block, fed from the top ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module gpc_pin_control_asserts #(
  parameter int LED_COUNT = 4
) (
  input wire logic sys_clk, // Clock
  input wire logic reset, // Reset
  input wire logic [4:0] reg_addr, // Index
  input wire logic reg_wr_en, // Write
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_rd_en, // Read
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic [14:0] gp_pin_out, // Pin values
  input wire logic low_power_hold_pin_out, // Hold value
  input wire logic low_power_hold_pin_oe, // Hold enable
  input wire logic [LED_COUNT-1:0] led_value, // LED wanted
  input wire logic [LED_COUNT-1:0] led_out, // LED value
  input wire logic [LED_COUNT-1:0] led_oe // LED enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Page tracker, since off-page writes must leave the pins alone
  logic on_gp_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) on_gp_ff <= 1'b0;
    else if (reg_wr_en && reg_addr == 5'h1f) on_gp_ff <= reg_wdata == 16'h0010;
  end
  wire logic wr_gp = reg_wr_en && on_gp_ff;
  // Mirror of the LED tri-state bit, so the enables can be predicted
  logic led_tri_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) led_tri_ff <= 1'b0;
    else if (wr_gp && reg_addr == 5'h0e) led_tri_ff <= reg_wdata[9];
  end
  hold_dir_a: assert property (
    wr_gp && reg_addr == 5'h0e |=> low_power_hold_pin_oe == !$past(reg_wdata[13]))
    else $error("hold pin enable wrong");
  hold_val_a: assert property (
    wr_gp && reg_addr == 5'h0e |=> low_power_hold_pin_out == $past(reg_wdata[12]))
    else $error("hold pin value wrong");
  out_load_a: assert property (
    wr_gp && reg_addr == 5'h10 |=> gp_pin_out == $past(reg_wdata[14:0]))
    else $error("pin values not loaded");
  out_keep_a: assert property (
    !(wr_gp && reg_addr == 5'h10) |=> $stable(gp_pin_out))
    else $error("pin values moved");
  led_val_a: assert property (led_out == led_value)
    else $error("led value wrong");
  led_drive_a: assert property (
    led_oe == (led_tri_ff ? ~led_value : {LED_COUNT{1'b1}}))
    else $error("led enable wrong");
  off_page_a: assert property (
    reg_rd_en && !on_gp_ff && reg_addr != 5'h1f |=> reg_rdata == 16'h0000)
    else $error("off page read not zero");
  ctrl_rsvd_a: assert property (
    reg_rd_en && reg_addr == 5'h0e |=> !reg_rdata[8])
    else $error("reserved bit set");
  top_rsvd_a: assert property (
    reg_rd_en && reg_addr inside {5'h0f, 5'h10} |=> !reg_rdata[15])
    else $error("bit 15 set");
  rd_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule : gpc_pin_control_asserts
bind gpc_pin_control gpc_pin_control_asserts #(.LED_COUNT(LED_COUNT))
  gpc_pin_control_asserts_inst (.sys_clk(sys_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
  .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .gp_pin_out(gp_pin_out),
  .low_power_hold_pin_out(low_power_hold_pin_out),
  .low_power_hold_pin_oe(low_power_hold_pin_oe), .led_value(led_value),
  .led_out(led_out), .led_oe(led_oe));
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the pin control block.
// Assumes the board model resolves the pin wires.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin \
  compares++; \
  if ((s) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, s); \
  end \
end
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, wdat;
  logic [7:0] low_pins_reg_ctrl = 8'ha5;
  logic [14:0] pin_lvl, gp_pin_out, gp_pin_oe;
  logic [14:0] ext_lvl = 15'h5a3c;
  logic hold_lvl, hold_out, hold_oe;
  logic ext_hold = 1'b0;
  logic [3:0] led_value = 4'ha;
  logic [3:0] led_out, led_oe;
  int compares = 0;
  int n_mismatch = 0;
  int cyc = 0;
  gpc_pin_control gpc_pin_control_inst (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .low_pins_reg_ctrl(low_pins_reg_ctrl), .gp_pin_in(pin_lvl),
    .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
    .low_power_hold_pin_in(hold_lvl), .low_power_hold_pin_out(hold_out),
    .low_power_hold_pin_oe(hold_oe), .led_value(led_value),
    .led_out(led_out), .led_oe(led_oe));
  gpc_board_model gpc_board_model_inst (.ext_lvl(ext_lvl),
    .ext_hold(ext_hold), .pin_out(gp_pin_out), .pin_oe(gp_pin_oe),
    .hold_out(hold_out), .hold_oe(hold_oe), .pin_lvl(pin_lvl),
    .hold_lvl(hold_lvl));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // Run is about a hundred cycles, so this only trips on a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  // Read data holds until the next strobe, so a late look is safe
  task automatic chkrd(input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    @(posedge sys_clk);
    `CHK("rdata", e, reg_rdata)
  endtask : chkrd
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    chkrd(5'h10, 16'h0000);
    wr(5'h10, 16'h7fff);
    wr(5'h1f, 16'h0010);
    chkrd(5'h10, 16'h0000);
    chkrd(5'h0e, 16'h2400);
    chkrd(5'h11, 16'h0000);
    chkrd(5'h0f, 16'h5a3c);
    `CHK("hold_oe", 1'b0, hold_oe)
    $display("reset and page test done");
    wr(5'h0e, 16'hffff);
    chkrd(5'h0e, 16'hf6ff);
    wr(5'h0e, 16'h1000);
    @(negedge sys_clk);
    `CHK("hold_oe", 1'b1, hold_oe)
    `CHK("hold_out", 1'b1, hold_out)
    repeat (5) @(posedge sys_clk);
    chkrd(5'h0e, 16'h1800);
    $display("hold pin test done");
    wr(5'h10, 16'h7fff);
    wr(5'h11, 16'hffff);
    chkrd(5'h11, 16'h7fff);
    for (int c = 0; c < 4; c++) begin
      wdat = {c[1:0], 1'b1, 2'h0, 1'b1, c[0], 1'b0, {4{c[1:0]}}};
      wr(5'h0e, wdat);
      repeat (5) @(posedge sys_clk);
      `CHK("upper_oe", (c == 3) ? 3'h7 : 3'h0, gp_pin_oe[14:12])
      `CHK("mid_oe", (c == 3) ? 4'hf : 4'h0, gp_pin_oe[11:8])
      `CHK("led_oe", c[0] ? ~led_value : 4'hf, led_oe)
      chkrd(5'h0e, wdat);
      $display("control code %0d done", c);
    end
    `CHK("low_oe", 8'ha5, gp_pin_oe[7:0])
    `CHK("pin_out", 15'h7fff, gp_pin_out)
    `CHK("led_out", 4'ha, led_out)
    ext_hold <= 1'b1;
    chkrd(5'h0f, 16'h7fbd);
    chkrd(5'h10, 16'h7fff);
    chkrd(5'h0e, 16'heeff);
    wr(5'h1f, 16'h0000);
    chkrd(5'h0e, 16'h0000);
    $display("pin data test done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
